// >>> rtl/escr_pend_pick.sv
/*
  Finds the highest-priority pending enabled external interrupt.
  Assumes 2-bit priorities per line, lower value wins, lower line number breaks ties.
*/
`timescale 1ns/1ps
module escr_pend_pick (
  input  wire logic [31:0] pend,      // Pending interrupt lines
  input  wire logic [31:0] enable,    // Enabled interrupt lines
  input  wire logic [63:0] prio,      // Two priority bits per line
  output logic             found,     // Some pending enabled line exists
  output logic [5:0]       exc_num    // Its exception number
);
  logic [2:0] best_p;
  always_comb begin
    found   = 1'b0;
    exc_num = 6'h00;
    best_p  = 3'h4;
    for (int i = escr_pkg::NUM_IRQ - 1; i >= 0; i--) begin
      if (pend[i] && enable[i] && ({1'b0, prio[2*i +: 2]} <= best_p)) begin
        best_p  = {1'b0, prio[2*i +: 2]};
        found   = 1'b1;
        exc_num = escr_pkg::IRQ_BASE + 6'(i);  // [R09]
      end
    end
  end
endmodule

// >>> rtl/escr_pkg.sv
/*
  Constants for the exception state and reset control register bank.
  Assumes a 32-bit classic Wishbone slave on one clock, synchronous active-low reset.
*/
// Notes on behaviour
// [R01] Writing 1 to bit 27 clears deferred service pending; 0 does nothing.
// [R02] Bit 26 write 1 sets tick pending; reads show tick pending state.
// [R03] Bit 25 is write-only; 1 clears tick pending; reads give no defined value.
// [R04] Without a tick timer, tick set and clear bits are reserved.
// [R05] Bit 22 reads 1 when any interrupt is pending, excluding NMI and faults.
// [R06] Field 17:12 gives highest-priority pending enabled exception number, else zero.
// [R07] Field 5:0 gives the active exception number, zero in thread mode.
// [R08] Active field always equals bits 5:0 of interrupt program status.
// [R09] Exception number n maps to interrupt line n minus 16.
// [R10] Software never sets and clears the same exception in one write.
// [R11] Reset control writes ignored unless bits 31:16 equal 0x05FA; they read unknown.
// [R12] Bit 15 reports implemented data endianness, 0 little, 1 big.
// [R13] Key-valid write with bit 2 set requests system reset; bit reads 0.
// [R14] Bit 1 is reserved for debug, reads 0; software writes 0.
// [R15] Bit 28 write 1 sets deferred service pending; reads show its pending state.
// [R16] Reserved bits of both registers read zero and ignore writes.
package escr_pkg;
  localparam logic [3:0]  ADDR_STATE      = 4'h0;   // Exception state register, byte address
  localparam logic [3:0]  ADDR_RESET_CTRL = 4'h4;   // Reset control register, byte address
  localparam int          BIT_DS_SET      = 28;
  localparam int          BIT_DS_CLR      = 27;
  localparam int          BIT_TICK_SET    = 26;
  localparam int          BIT_TICK_CLR    = 25;
  localparam int          BIT_ANY_PEND    = 22;
  localparam int          POS_HIGH_PEND   = 12;
  localparam int          POS_ACTIVE      = 0;
  localparam int          BIT_ENDIAN      = 15;
  localparam int          BIT_SYS_RESET   = 2;
  localparam int          POS_KEY         = 16;
  localparam logic [15:0] WRITE_KEY       = 16'h05fa;
  localparam logic [5:0]  IRQ_BASE        = 6'h10;  // First external interrupt exception number
  localparam int          NUM_IRQ         = 32;
  localparam logic [7:0]  RESET_PULSE_CYC = 8'h04;  // Length of the system reset request pulse
  localparam logic [31:0] RESET_VALUE     = 32'h0000_0000;
endpackage

// >>> rtl/escr_regs.sv
/*
  Exception state register and reset control register behind a classic Wishbone slave.
  Assumes the core supplies its pending, enable, priority and status signals synchronously.
*/
`timescale 1ns/1ps
module escr_regs #(
  parameter bit HAS_TICK = 1'b1,   // System tick timer implemented
  parameter bit BIG_END  = 1'b0    // Implemented data endianness
) (
  input  wire logic        clk_sys,        // 20 MHz clock
  input  wire logic        rst_n,          // Synchronous reset, active low
  input  wire logic        wb_cyc_i,       // Wishbone cycle
  input  wire logic        wb_stb_i,       // Wishbone strobe
  input  wire logic        wb_we_i,        // Write enable
  input  wire logic [3:0]  wb_adr_i,       // Byte address
  input  wire logic [3:0]  wb_sel_i,       // Byte selects
  input  wire logic [31:0] wb_dat_i,       // Write data
  output logic [31:0]      wb_dat_o,       // Read data
  output logic             wb_ack_o,       // Acknowledge
  input  wire logic [31:0] irq_pend,       // External interrupt pending lines
  input  wire logic [31:0] irq_enable,     // External interrupt enables
  input  wire logic [63:0] irq_prio,       // Two priority bits per line
  input  wire logic [5:0]  interrupt_program_status, // Active exception from the core
  input  wire logic        tick_event,     // Tick timer makes its exception pending
  input  wire logic        ds_taken,       // Core entered the deferred service handler
  input  wire logic        tick_taken,     // Core entered the tick handler
  output logic             ds_pending,     // Deferred service exception pending
  output logic             tick_pending,   // System tick exception pending
  output logic             system_reset_request // System reset request pulse
);
  logic        ds_q, ds_d;
  logic        tick_q, tick_d;
  logic        ack_q, ack_d;
  logic [31:0] rdata_q, rdata_d;
  logic [7:0]  rst_cnt_q, rst_cnt_d;
  logic        rst_req_q, rst_req_d;
  logic        ds_out_q, tick_out_q;
  logic        pick_found;
  logic [5:0]  pick_num;
  logic        req, wr_state, wr_reset, key_ok, full_word;
  logic [5:0]  high_pend;

  escr_pend_pick u_pick (
    .pend    (irq_pend),
    .enable  (irq_enable),
    .prio    (irq_prio),
    .found   (pick_found),
    .exc_num (pick_num)
  );

  // Deferred service and tick are system exceptions that also count as pending interrupts
  always_comb begin
    if (pick_found) begin
      high_pend = pick_num;                      // [R06]
    end else if (ds_q) begin
      high_pend = 6'h0e;
    end else if (tick_q && HAS_TICK) begin
      high_pend = 6'h0f;
    end else begin
      high_pend = 6'h00;                         // [R06]
    end
  end

  always_comb begin
    req       = wb_cyc_i && wb_stb_i && !ack_q;
    full_word = (wb_sel_i == 4'hf);
    wr_state  = req && wb_we_i && full_word && (wb_adr_i == escr_pkg::ADDR_STATE);
    key_ok    = wb_dat_i[escr_pkg::POS_KEY +: 16] == escr_pkg::WRITE_KEY;       // [R11]
    wr_reset  = req && wb_we_i && full_word && (wb_adr_i == escr_pkg::ADDR_RESET_CTRL) && key_ok; // [R11]
  end

  always_comb begin
    ds_d   = ds_q;
    tick_d = tick_q;
    if (ds_taken) begin
      ds_d = 1'b0;
    end
    if (tick_taken) begin
      tick_d = 1'b0;
    end
    if (wr_state && wb_dat_i[escr_pkg::BIT_DS_CLR]) begin
      ds_d = 1'b0;                               // [R01]
    end
    if (wr_state && wb_dat_i[escr_pkg::BIT_DS_SET]) begin
      ds_d = 1'b1;                               // [R15] [R10]
    end
    if (HAS_TICK) begin                          // [R04]
      if (wr_state && wb_dat_i[escr_pkg::BIT_TICK_CLR]) begin
        tick_d = 1'b0;                           // [R03]
      end
      if ((wr_state && wb_dat_i[escr_pkg::BIT_TICK_SET]) || tick_event) begin
        tick_d = 1'b1;                           // [R02]
      end
    end else begin
      tick_d = 1'b0;                             // [R04]
    end
  end

  always_comb begin
    ack_d   = req;
    rdata_d = 32'h0000_0000;                     // [R16]
    if (req && !wb_we_i) begin
      unique case (wb_adr_i)
        escr_pkg::ADDR_STATE: begin
          rdata_d[escr_pkg::BIT_DS_SET]   = ds_q;                          // [R15]
          rdata_d[escr_pkg::BIT_TICK_SET] = tick_q && HAS_TICK;            // [R02] [R04]
          rdata_d[escr_pkg::BIT_ANY_PEND] = |(irq_pend) || ds_q || tick_q; // [R05]
          rdata_d[escr_pkg::POS_HIGH_PEND +: 6] = high_pend;              // [R06]
          rdata_d[escr_pkg::POS_ACTIVE +: 6]    = interrupt_program_status; // [R07] [R08]
        end
        escr_pkg::ADDR_RESET_CTRL: begin
          rdata_d[escr_pkg::BIT_ENDIAN] = BIG_END; // [R12] [R13] [R14]
        end
        default: begin
          rdata_d = 32'h0000_0000;
        end
      endcase
    end
  end

  // Reset request is stretched so the system reset controller cannot miss it
  always_comb begin
    rst_cnt_d = rst_cnt_q;
    rst_req_d = 1'b0;
    if (wr_reset && wb_dat_i[escr_pkg::BIT_SYS_RESET]) begin
      rst_cnt_d = escr_pkg::RESET_PULSE_CYC;   // [R13]
    end else if (rst_cnt_q != 8'h00) begin
      rst_cnt_d = rst_cnt_q - 8'h01;
    end
    rst_req_d = (rst_cnt_d != 8'h00);
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      ds_q       <= 1'b0;
      tick_q     <= 1'b0;
      ack_q      <= 1'b0;
      rdata_q    <= escr_pkg::RESET_VALUE;
      rst_cnt_q  <= 8'h00;
      rst_req_q  <= 1'b0;
      ds_out_q   <= 1'b0;
      tick_out_q <= 1'b0;
    end else begin
      ds_q       <= ds_d;
      tick_q     <= tick_d;
      ack_q      <= ack_d;
      rdata_q    <= rdata_d;
      rst_cnt_q  <= rst_cnt_d;
      rst_req_q  <= rst_req_d;
      ds_out_q   <= ds_d;
      tick_out_q <= tick_d;
    end
  end

  assign wb_dat_o             = rdata_q;
  assign wb_ack_o             = ack_q;
  assign ds_pending           = ds_out_q;
  assign tick_pending         = tick_out_q;
  assign system_reset_request = rst_req_q;
endmodule

// >>> sim/escr_regs_asserts.sv
/* Port checker for the exception state and reset control bank.
   Assumes a bind to escr_regs with default parameters. */
`timescale 1ns/1ps
module escr_regs_asserts (
  input wire logic        clk_sys,
  input wire logic        rst_n,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [3:0]  wb_adr_i,
  input wire logic [3:0]  wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  input wire logic [31:0] irq_pend,
  input wire logic [5:0]  interrupt_program_status,
  input wire logic        tick_event,
  input wire logic        ds_pending,
  input wire logic        tick_pending,
  input wire logic        system_reset_request
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  wire t  = wb_cyc_i && wb_stb_i && !wb_ack_o && wb_we_i && wb_sel_i == 4'hf;
  wire w0 = t && wb_adr_i == 4'h0;
  wire w4 = t && wb_adr_i == 4'h4;
  wire k  = wb_dat_i[31:16] == 16'h05fa;
  wire r0 = wb_ack_o && !wb_we_i && wb_adr_i == 4'h0;
  sequence pulse_s;
    system_reset_request [*4] ##1 !system_reset_request;
  endsequence
  ds_set_a: assert property (w0 && wb_dat_i[28] |=> ds_pending)
    else $error("ds set");
  ds_clr_a: assert property (w0 && wb_dat_i[27] && !wb_dat_i[28] |=> !ds_pending)
    else $error("ds clear");
  tick_set_a: assert property (w0 && wb_dat_i[26] |=> tick_pending)
    else $error("tick set");
  tick_clr_a: assert property (w0 && wb_dat_i[25] && !wb_dat_i[26] && !tick_event |=> !tick_pending)
    else $error("tick clear");
  key_gate_a: assert property (w4 && !k && !system_reset_request |=> !system_reset_request)
    else $error("bad key");
  reset_pulse_a: assert property (w4 && k && wb_dat_i[2] && !system_reset_request |=> pulse_s)
    else $error("reset pulse");
  any_pend_a: assert property (r0 |-> wb_dat_o[22] == $past(|irq_pend || ds_pending || tick_pending))
    else $error("any pending");
  active_num_a: assert property (r0 |-> wb_dat_o[5:0] == $past(interrupt_program_status))
    else $error("active number");
  resv_zero_a: assert property (wb_ack_o && !wb_we_i |->
    (wb_dat_o & (wb_adr_i[2] ? 32'hffff_ffff : 32'hebbc_0fc0)) == 32'h0) else $error("reserved bits");
endmodule

// >>> sim/tb_escr_regs.sv
/* Self-checking bench for the exception state and reset control bank.
   Assumes escr_regs with default parameters; binds the port checker. */
`timescale 1ns/1ps
module tb_escr_regs;
  logic        clk_sys, rst_n, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, system_reset_request;
  logic        tick_event, ds_taken, tick_taken;
  logic [3:0]  wb_adr_i, wb_sel_i;
  logic [5:0]  ips, k;
  logic [31:0] wb_dat_i, wb_dat_o, irq_pend, irq_enable, pulses, xq[$];
  logic [63:0] irq_prio;
  int          num_errors, n_checks, cycles;
  integer      seed = 32'hef8aea5d;
  escr_regs i_dut (.*, .interrupt_program_status(ips), .ds_pending(), .tick_pending());
  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end
  function automatic logic [31:0] st(input logic d, t, input logic [5:0] h);
    return {3'h0, d, 1'b0, t, 3'h0, d | t | (h != 6'h0), 4'h0, h, 6'h0, ips};
  endfunction
  task automatic chk(input logic [31:0] g, x);
    n_checks++;
    if (g !== x) begin
      num_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, x);
    end
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // Holds the request until ack is sampled, then idles one cycle
  task automatic bus(input logic w, input logic [3:0] a, s, input logic [31:0] d, x);
    if (!w) xq.push_back(x);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= w;
    wb_adr_i <= a;
    wb_sel_i <= s;
    wb_dat_i <= d;
    do @(posedge clk_sys); while (wb_ack_o !== 1'b1);
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge clk_sys);
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] x);
    bus(1'b0, a, 4'hf, 32'h0, x);
  endtask
  always @(posedge clk_sys) begin
    cycles++;
    if (system_reset_request === 1'b1) pulses <= pulses + 32'h1;
    if (wb_ack_o === 1'b1 && wb_we_i === 1'b0) chk(wb_dat_o, xq.pop_front());
    if (cycles == 2000) begin
      num_errors++;
      finish_test();
    end
  end
  initial begin
    {rst_n, wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i, wb_dat_i, irq_pend, irq_enable, irq_prio, pulses} = '0;
    {tick_event, ds_taken, tick_taken} = 3'h0;
    ips = 6'($random(seed));
    repeat (20) @(posedge clk_sys);
    rst_n <= 1'b1;
    @(posedge clk_sys);
    rd(4'h0, st(1'b0, 1'b0, 6'h0));
    rd(4'h4, 32'h0);
    rd(4'h8, 32'h0);
    bus(1'b1, 4'h0, 4'h3, 32'h1000_0000, 32'h0);
    rd(4'h0, st(1'b0, 1'b0, 6'h0));
    $display("test reset values done");
    bus(1'b1, 4'h0, 4'hf, 32'h1000_0000, 32'h0);
    rd(4'h0, st(1'b1, 1'b0, 6'he));
    bus(1'b1, 4'h0, 4'hf, 32'h0800_0000, 32'h0);
    rd(4'h0, st(1'b0, 1'b0, 6'h0));
    bus(1'b1, 4'h0, 4'hf, 32'h0400_0000, 32'h0);
    rd(4'h0, st(1'b0, 1'b1, 6'hf));
    bus(1'b1, 4'h0, 4'hf, 32'h0200_0000, 32'h0);
    rd(4'h0, st(1'b0, 1'b0, 6'h0));
    tick_event <= 1'b1;
    @(posedge clk_sys);
    tick_event <= 1'b0;
    rd(4'h0, st(1'b0, 1'b1, 6'hf));
    bus(1'b1, 4'h0, 4'hf, 32'h1000_0000, 32'h0);
    ds_taken   <= 1'b1;
    tick_taken <= 1'b1;
    @(posedge clk_sys);
    ds_taken   <= 1'b0;
    tick_taken <= 1'b0;
    rd(4'h0, st(1'b0, 1'b0, 6'h0));
    repeat (6) begin
      k = 6'($random(seed)) & 6'h1f;
      irq_pend   <= 32'h1 << k;
      irq_enable <= 32'h1 << k;
      irq_prio   <= {$random(seed), $random(seed)};
      @(posedge clk_sys);
      rd(4'h0, st(1'b0, 1'b0, k + 6'h10));
    end
    $display("test pending state done");
    bus(1'b1, 4'h4, 4'hf, 32'h05fb_0004, 32'h0);
    bus(1'b1, 4'h4, 4'hf, 32'h05fa_0004, 32'h0);
    repeat (6) @(posedge clk_sys);
    chk(pulses, 32'h4);
    $display("test reset request done");
    finish_test();
  end
endmodule
bind escr_regs escr_regs_asserts i_chk (.*);
